// ==== ecpm_pkg.sv ====
// constants and types of the extended parallel-port mode control
// Contract
// [RULE_01] config B bit 6 shows irq line level; bits 5:0 read zero
// [RULE_02] extended control register at 402h holds read/write mode in bits 7:5
// [RULE_03] bit 4 set blocks fault irq; clear pulses irq on fault falling edge; code raises fault irqs in mode 011 only
// [RULE_04] clearing bit 4 while fault already asserted raises irq at once; code does this in mode 011 only
// [RULE_05] bit 3 enables dma, transfers only while service bit is 0
// [RULE_06] service bit set disables dma and service irqs; writing 1 never interrupts
// [RULE_07] hardware sets service bit after a service irq; software clears it
// [RULE_08] with dma enabled, terminal count sets the service bit
// [RULE_09] without dma, free space or fill level reaching threshold sets service bit
// [RULE_10] bit 1 reads fifo full, bit 0 reads fifo empty
// [RULE_11] mode 000 resets fifo, open-collector controls, direction ignored
// [RULE_12] mode 001 direction floats data, data read returns pins, push-pull
// [RULE_13] mode 010 sends fifo bytes with compatibility handshake, forward only
// [RULE_14] mode 011 shares fifo for address and data forward, packs bytes reverse
// [RULE_15] mode 100 is epp only when option enabled; 101 reserved
// [RULE_16] mode 110 fifo host accessible, never sent out, push-pull
// [RULE_17] mode 111 maps config A and B at 400h and 401h
// [RULE_18] entering 010 or 011 starts automatic handshake
// [RULE_19] software leaves non-000/001 modes only to 000 or 001
// [RULE_20] software changes direction only in mode 001
// [RULE_21] control outputs deasserted before a mode change takes effect
// [RULE_22] leaving ecp reverse drops surplus bytes and releases auto-feed at once
// [RULE_23] each irq is a short low pulse then the line floats
// [RULE_24] threshold setting 0..15 means effective threshold 1..16
`default_nettype none
package ecpm_pkg;
  localparam logic [2:0]  MODE_SPP  = 3'h0;
  localparam logic [2:0]  MODE_PS2  = 3'h1;
  localparam logic [2:0]  MODE_FIFO = 3'h2;
  localparam logic [2:0]  MODE_ECP  = 3'h3;
  localparam logic [2:0]  MODE_EPP  = 3'h4;
  localparam logic [2:0]  MODE_TEST = 3'h6;
  localparam logic [2:0]  MODE_CFG  = 3'h7;
  localparam logic [10:0] OFS_DATA  = 11'h000;
  localparam logic [10:0] OFS_CTRL  = 11'h002;
  localparam logic [10:0] OFS_QUEUE = 11'h400;
  localparam logic [10:0] OFS_CFGB  = 11'h401;
  localparam logic [10:0] OFS_ECR   = 11'h402;
  localparam int          ECR_MODE  = 5;
  localparam int          ECR_MASK  = 4;
  localparam int          ECR_DMA   = 3;
  localparam int          ECR_SVC   = 2;
  localparam int          CFGB_IRQ  = 6;
  localparam int          CTL_DIR   = 5;
  localparam logic [7:0]  CFGA_VAL  = 8'h10;
  localparam logic        SVC_RST   = 1'h1;
  localparam logic        MASK_RST  = 1'h0;
  localparam longint      CLK_HZ    = 40000000;
  localparam longint      IRQ_NS    = 100;
  localparam longint      SETUP_NS  = 500;
  localparam logic [3:0]  IRQ_CYC   = 4'((IRQ_NS * CLK_HZ) / 1000000000);
  localparam logic [5:0]  SETUP_CYC = 6'((SETUP_NS * CLK_HZ + 999999999) / 1000000000);
  typedef enum logic [1:0] {
    HS_IDLE   = 2'h0,
    HS_SETUP  = 2'h1,
    HS_STROBE = 2'h3,
    HS_HOLD   = 2'h2
  } ecpm_hs_e;
endpackage
`default_nettype wire

// ==== ecpm_sync.sv ====
// two-stage synchroniser for pin inputs
`default_nettype none
module ecpm_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] rst_val,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      meta_r <= rst_val;
      q      <= rst_val;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // ecpm_sync
`default_nettype wire

// ==== ecpm_fifo.sv ====
// flip-flop fifo with flush
`default_nettype none
module ecpm_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 16,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic          flush,
  input  wire logic          push,
  input  wire logic [W-1:0]  pushData,
  input  wire logic          pop,
  output logic      [W-1:0]  popData,
  output logic      [CW-1:0] count,
  output logic               full,
  output logic               empty
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [CW-1:0] cnt_r;
  logic          doPush;
  logic          doPop;

  assign full    = (cnt_r == DEPTH_C);
  assign empty   = (cnt_r == '0);
  assign count   = cnt_r;
  assign popData = mem_r[rdPtr_r];
  assign doPush  = push && !full;
  assign doPop   = pop && !empty;

  always_ff @(posedge clk)
  begin
    if (doPush)
      mem_r[wrPtr_r] <= pushData;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst || flush)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      cnt_r   <= '0;
    end
    else
    begin
      if (doPush)
        wrPtr_r <= (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
      if (doPop)
        rdPtr_r <= (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
      if (doPush && !doPop)
        cnt_r <= cnt_r + 1'b1;
      else if (doPop && !doPush)
        cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule // ecpm_fifo
`default_nettype wire

// ==== ecpm_port_ctrl.sv ====
// extended parallel-port mode control top
`default_nettype none
module ecpm_port_ctrl
  import ecpm_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [10:0] isaAddr,
  input  wire logic [7:0]  isaDataIn,
  input  wire logic        isaRdN,
  input  wire logic        isaWrN,
  output logic      [7:0]  isaDataOut,
  output logic             isaDataOeN,
  input  wire logic        dmaTc,
  output logic             dmaRun,
  input  wire logic        eppOption,
  input  wire logic [3:0]  queueLevelSetting,
  input  wire logic        irqLineLevel,
  output logic             irqOut,
  output logic             irqOeN,
  input  wire logic [7:0]  pdIn,
  output logic      [7:0]  pdOut,
  output logic             pdOeN,
  input  wire logic        periphBusy,
  input  wire logic        periphAckN,
  input  wire logic        periphErrorInN,
  output logic             dataStrobeOutN,
  output logic             dataStrobeOeN,
  output logic             lineFeedOutN,
  output logic             lineFeedOeN,
  output logic             periphInitOutN,
  output logic             periphInitOeN,
  output logic             periphSelectOutN,
  output logic             periphSelectOeN,
  output logic             eppActive
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  // ==========================================================
  // pin synchronisers
  logic [33:0] syncQ;
  logic        rdS;
  logic        wrS;
  logic [10:0] addrS;
  logic [7:0]  dinS;
  logic [7:0]  pdS;
  logic        busyS;
  logic        ackNS;
  logic        faultNS;
  logic        irqLvlS;
  logic        tcS;

  ecpm_sync #(.W(34)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .rst_val ({2'h3, 19'h0, 8'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0}),
    .d       ({isaRdN, isaWrN, isaAddr, isaDataIn, pdIn, periphBusy,
                periphAckN, periphErrorInN, irqLineLevel, dmaTc}),
    .q       (syncQ)
  );
  assign {rdS, wrS, addrS, dinS, pdS, busyS, ackNS, faultNS, irqLvlS, tcS} = syncQ;

  // ==========================================================
  // strobe edges
  logic rdPrev_r;
  logic wrPrev_r;
  logic faultPrev_r;
  logic tcPrev_r;
  logic rdEdge;
  logic wrEdge;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rdPrev_r    <= 1'b1;
      wrPrev_r    <= 1'b1;
      faultPrev_r <= 1'b1;
      tcPrev_r    <= 1'b0;
    end
    else
    begin
      rdPrev_r    <= rdS;
      wrPrev_r    <= wrS;
      faultPrev_r <= faultNS;
      tcPrev_r    <= tcS;
    end
  end
  assign rdEdge = rdPrev_r && !rdS;
  assign wrEdge = !wrPrev_r && wrS;

  // ==========================================================
  // registers
  logic [2:0] mode_r;
  logic [2:0] pendMode_r;
  logic       modeChg_r;
  logic       faultMask_r;
  logic       dmaOn_r;
  logic       svcBlock_r;
  logic [7:0] dataReg_r;
  logic [5:0] ctrl_r;
  logic       wrEcr;
  logic       dirRev;
  logic       fifoMode;
  logic       ecpRev;

  assign wrEcr    = wrEdge && (addrS == OFS_ECR);
  assign dirRev   = ctrl_r[CTL_DIR];
  assign fifoMode = (mode_r == MODE_FIFO) || (mode_r == MODE_ECP) || (mode_r == MODE_TEST);
  assign ecpRev   = (mode_r == MODE_ECP) && dirRev;

  // [RULE_02] mode field write
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mode_r     <= MODE_SPP;
      pendMode_r <= MODE_SPP;
      modeChg_r  <= 1'b0;
    end
    else if (modeChg_r)
    begin
      mode_r    <= pendMode_r;
      modeChg_r <= 1'b0;
    end
    else if (wrEcr && (dinS[7:ECR_MODE] != mode_r))
    begin
      // [RULE_21] one cycle of released controls
      pendMode_r <= dinS[7:ECR_MODE];
      modeChg_r  <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dataReg_r <= '0;
      ctrl_r    <= '0;
    end
    else if (wrEdge && addrS == OFS_DATA)
      dataReg_r <= dinS;
    else if (wrEdge && addrS == OFS_CTRL)
      ctrl_r <= dinS[5:0];
  end

  // ==========================================================
  // fifo
  logic          fPush;
  logic [8:0]    fPushData;
  logic          fPop;
  logic [8:0]    fHead;
  logic [CW-1:0] fCount;
  logic          fFull;
  logic          fEmpty;
  logic          fFlush;
  logic          hsPop;
  logic          hsPush;
  logic          hostPush;
  logic          hostPop;

  // [RULE_11] fifo held reset in mode 000
  // [RULE_22] surplus reverse bytes dropped
  assign fFlush   = (mode_r == MODE_SPP) || (modeChg_r && ecpRev);
  // [RULE_14] address/rle and data share one queue
  assign hostPush = wrEdge && !fFull && ((addrS == OFS_QUEUE &&
                    (mode_r == MODE_FIFO || mode_r == MODE_TEST ||
                    (mode_r == MODE_ECP && !dirRev))) ||
                    (addrS == OFS_DATA && mode_r == MODE_ECP && !dirRev));
  // [RULE_16] test mode host reads pop the queue
  assign hostPop  = rdEdge && addrS == OFS_QUEUE && (mode_r == MODE_TEST || ecpRev);
  assign fPush    = hostPush || hsPush;
  assign fPushData = hsPush ? {1'b0, pdS} : {addrS == OFS_DATA, dinS};
  assign fPop     = hostPop || hsPop;

  ecpm_fifo #(.W(9), .DEPTH(DEPTH)) u_fifo (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .flush    (fFlush),
    .push     (fPush),
    .pushData (fPushData),
    .pop      (fPop),
    .popData  (fHead),
    .count    (fCount),
    .full     (fFull),
    .empty    (fEmpty)
  );

  // ==========================================================
  // service and fault events
  logic [CW-1:0] thr;
  logic          svcCond;
  logic          svcEvent;
  logic          faultIrq;
  logic          irqStart;

  // [RULE_24] effective threshold is setting plus one
  assign thr = CW'({1'b0, queueLevelSetting}) + CW'(1);
  always_comb
  begin
    if (!fifoMode)
      svcCond = 1'b0;
    // [RULE_08] terminal count event
    else if (dmaOn_r)
      svcCond = tcS && !tcPrev_r;
    // [RULE_09] threshold events
    else if (!dirRev || mode_r == MODE_FIFO)
      svcCond = (DEPTH_C - fCount) >= thr;
    else
      svcCond = fCount >= thr;
  end
  // [RULE_06] blocked while service bit set
  assign svcEvent = !svcBlock_r && svcCond;
  // [RULE_03] fault falling edge
  // [RULE_04] unmask while fault asserted
  assign faultIrq = (mode_r == MODE_ECP) && ((!faultMask_r && faultPrev_r && !faultNS) ||
                    (wrEcr && faultMask_r && !dinS[ECR_MASK] && !faultNS));
  assign irqStart = svcEvent || faultIrq;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      faultMask_r <= MASK_RST;
      dmaOn_r     <= 1'b0;
    end
    else if (wrEcr)
    begin
      faultMask_r <= dinS[ECR_MASK];
      dmaOn_r     <= dinS[ECR_DMA];
    end
  end

  // [RULE_07] hardware sets service bit, set beats clear
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      svcBlock_r <= SVC_RST;
    else if (svcEvent)
      svcBlock_r <= 1'b1;
    else if (wrEcr)
      svcBlock_r <= dinS[ECR_SVC];
  end

  // [RULE_05] dma gated by service bit
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      dmaRun <= 1'b0;
    else
      dmaRun <= dmaOn_r && !svcBlock_r && fifoMode && !modeChg_r;
  end

  // [RULE_15] epp only with chip option
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      eppActive <= 1'b0;
    else
      eppActive <= (mode_r == MODE_EPP) && eppOption;
  end

  // [RULE_23] short low pulse then float
  logic [3:0] irqCnt_r;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      irqCnt_r <= '0;
      irqOut   <= 1'b0;
      irqOeN   <= 1'b1;
    end
    else
    begin
      irqOut <= 1'b0;
      if (irqStart && irqCnt_r == '0)
        irqCnt_r <= IRQ_CYC;
      else if (irqCnt_r != '0)
        irqCnt_r <= irqCnt_r - 1'b1;
      irqOeN <= !((irqStart && irqCnt_r == '0) || irqCnt_r > 4'h1);
    end
  end

  // ==========================================================
  // host reads
  logic [7:0] lastRd_r;
  logic [7:0] rdVal;

  always_comb
  begin
    rdVal = '0;
    case (addrS)
      // [RULE_12] ps2 data read returns pins
      OFS_DATA:  rdVal = (mode_r == MODE_SPP) ? dataReg_r : pdS;
      OFS_CTRL:  rdVal = {2'h0, ctrl_r};
      // [RULE_17] config A in place of the queue
      OFS_QUEUE: rdVal = (mode_r == MODE_CFG) ? CFGA_VAL :
                         (fEmpty ? lastRd_r : fHead[7:0]);
      // [RULE_01] irq line level in config B
      OFS_CFGB:  rdVal = (mode_r == MODE_CFG) ? {1'b0, irqLvlS, 6'h0} : 8'h0;
      // [RULE_10] full and empty flags
      OFS_ECR:   rdVal = {mode_r, faultMask_r, dmaOn_r, svcBlock_r, fFull, fEmpty};
      default:   rdVal = '0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      isaDataOut <= '0;
      isaDataOeN <= 1'b1;
      lastRd_r   <= '0;
    end
    else
    begin
      isaDataOeN <= rdS;
      if (rdEdge)
        isaDataOut <= rdVal;
      if (hostPop && !fEmpty)
        lastRd_r <= fHead[7:0];
    end
  end

  // ==========================================================
  // automatic handshake engine
  ecpm_hs_e   hs_r;
  logic [5:0] hsTimer_r;
  logic [7:0] hsData_r;
  logic       hsStrobeN_r;
  logic       hsFeedN_r;
  logic       autoMode;

  // [RULE_18] modes 010 and 011 run the handshake
  assign autoMode = (mode_r == MODE_FIFO || mode_r == MODE_ECP) && !modeChg_r;
  // [RULE_13] forward sends pop the queue
  assign hsPop  = autoMode && !ecpRev && hs_r == HS_IDLE && !fEmpty && !busyS;
  assign hsPush = autoMode && ecpRev && hs_r == HS_IDLE && !ackNS && !fFull;

  always_ff @(posedge clk)
  begin
    if (sys_rst || !autoMode)
    begin
      hs_r        <= HS_IDLE;
      hsTimer_r   <= '0;
      hsData_r    <= '0;
      hsStrobeN_r <= 1'b1;
      hsFeedN_r   <= 1'b1;
    end
    else if (ecpRev)
    begin
      // [RULE_14] reverse bytes packed into the queue
      case (hs_r)
        HS_IDLE:
        begin
          hsFeedN_r <= 1'b0;
          if (hsPush)
          begin
            hsFeedN_r <= 1'b1;
            hs_r      <= HS_HOLD;
          end
        end
        HS_HOLD:
        begin
          if (ackNS)
          begin
            hsFeedN_r <= 1'b0;
            hs_r      <= HS_IDLE;
          end
        end
        default: hs_r <= HS_IDLE;
      endcase
    end
    else
    begin
      case (hs_r)
        HS_IDLE:
        begin
          if (hsPop)
          begin
            hsData_r  <= fHead[7:0];
            hsFeedN_r <= (mode_r == MODE_ECP) ? !fHead[8] : 1'b1;
            hsTimer_r <= SETUP_CYC;
            hs_r      <= HS_SETUP;
          end
        end
        HS_SETUP:
        begin
          if (hsTimer_r <= 6'h1)
          begin
            hsStrobeN_r <= 1'b0;
            hs_r        <= HS_STROBE;
          end
          else
            hsTimer_r <= hsTimer_r - 1'b1;
        end
        HS_STROBE:
        begin
          if (busyS)
          begin
            hsStrobeN_r <= 1'b1;
            hs_r        <= HS_HOLD;
          end
        end
        HS_HOLD:
        begin
          if (!busyS)
            hs_r <= HS_IDLE;
        end
        default: hs_r <= HS_IDLE;
      endcase
    end
  end

  // ==========================================================
  // pin drivers
  logic [3:0] ctlLvl;
  logic       drvData;

  always_comb
  begin
    ctlLvl = {!ctrl_r[3], ctrl_r[2], !ctrl_r[1], !ctrl_r[0]};
    if (autoMode)
    begin
      ctlLvl[0] = hsStrobeN_r;
      ctlLvl[1] = hsFeedN_r;
    end
    // [RULE_21] controls released during a mode change
    // [RULE_22] auto-feed released at once
    if (modeChg_r)
      ctlLvl = {1'b1, 1'b1, 1'b1, 1'b1};
  end
  // [RULE_11] direction ignored in 000 and 010
  assign drvData = (mode_r == MODE_SPP) || (mode_r == MODE_FIFO) || !dirRev;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      {periphSelectOutN, periphInitOutN, lineFeedOutN, dataStrobeOutN} <= 4'hf;
      {periphSelectOeN, periphInitOeN, lineFeedOeN, dataStrobeOeN}     <= 4'hf;
      pdOut <= '0;
      pdOeN <= 1'b1;
    end
    else
    begin
      {periphSelectOutN, periphInitOutN, lineFeedOutN, dataStrobeOutN} <= ctlLvl;
      // [RULE_11] open-collector controls in mode 000
      if (mode_r == MODE_SPP)
        {periphSelectOeN, periphInitOeN, lineFeedOeN, dataStrobeOeN} <= ctlLvl;
      else
        {periphSelectOeN, periphInitOeN, lineFeedOeN, dataStrobeOeN} <= 4'h0;
      // [RULE_12] direction floats data lines
      pdOeN <= !drvData;
      pdOut <= autoMode ? hsData_r : dataReg_r;
    end
  end
endmodule // ecpm_port_ctrl
`default_nettype wire

// ==== ecpm_port_ctrl_chk.sv ====
// assertion checker on the port mode control top ports
`default_nettype none
module ecpm_port_ctrl_chk (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       isaRdN,
  input wire logic       isaDataOeN,
  input wire logic       dmaTc,
  input wire logic       dmaRun,
  input wire logic       eppOption,
  input wire logic       eppActive,
  input wire logic       irqOut,
  input wire logic       irqOeN,
  input wire logic [7:0] pdOut,
  input wire logic       periphBusy,
  input wire logic       dataStrobeOutN,
  input wire logic       dataStrobeOeN,
  input wire logic       lineFeedOutN,
  input wire logic       lineFeedOeN
);
  // ==========================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  irq_pulse_len_a: assert property ($fell(irqOeN) |=> !irqOeN [*3] ##1 irqOeN)
    else $error("irq pulse length wrong");
  irq_low_only_a: assert property (!irqOeN |-> !irqOut)
    else $error("irq driven high");
  tc_stops_dma_a: assert property ($rose(dmaTc) && dmaRun |-> ##[1:8] !dmaRun)
    else $error("dma still running after terminal count");
  tc_raises_irq_a: assert property ($rose(dmaTc) && dmaRun |-> ##[1:8] !irqOeN)
    else $error("no irq after terminal count");
  strobe_oc_a: assert property (dataStrobeOeN |-> dataStrobeOutN)
    else $error("strobe released while low");
  feed_oc_a: assert property (lineFeedOeN |-> lineFeedOutN)
    else $error("line feed released while low");
  epp_gate_a: assert property (eppActive |-> $past(eppOption))
    else $error("epp active without option");
  rd_drive_a: assert property ($fell(isaRdN) |-> ##[2:4] !isaDataOeN)
    else $error("read data not driven");
  strobe_data_a: assert property (!dataStrobeOutN |-> $stable(pdOut))
    else $error("data moved under strobe");
  strobe_busy_a: assert property ($fell(dataStrobeOutN) |-> !periphBusy)
    else $error("strobe while peripheral busy");
endmodule // ecpm_port_ctrl_chk
`default_nettype wire

// ==== ecpm_periph_model.sv ====
// printer-side model answering the forward strobe handshake
`default_nettype none
module ecpm_periph_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       strobeN,
  input  wire logic [7:0] pdOut,
  input  wire logic [3:0] lag,
  output logic            busy,
  output logic            ackN,
  output logic [7:0]      lastByte,
  output int              count
);
  logic [3:0] waitCnt;
  // ==========================================
  // busy answers strobe
  always_ff @(posedge clk)
  begin
    ackN <= 1'b1;
    if (sys_rst)
    begin
      busy <= 1'b0;
      waitCnt <= 4'h0;
      count <= 0;
      lastByte <= 8'h00;
    end
    else if (!busy && !strobeN)
    begin
      waitCnt <= waitCnt + 4'h1;
      if (waitCnt == lag)
      begin
        busy <= 1'b1;
        lastByte <= pdOut;
        count <= count + 1;
        waitCnt <= 4'h0;
      end
    end
    else if (busy && strobeN)
    begin
      waitCnt <= waitCnt + 4'h1;
      if (waitCnt == 4'h3)
      begin
        busy <= 1'b0;
        waitCnt <= 4'h0;
      end
    end
  end
endmodule // ecpm_periph_model
`default_nettype wire

// ==== ecp_port_mode_control_bench.sv ====
// self-checking bench for the port mode control block
`default_nettype none
module ecp_port_mode_control_bench
  import ecpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 16;
  logic clk, sys_rst, isaRdN, isaWrN, isaDataOeN, dmaTc, dmaRun, eppOption, irqLineLevel;
  logic irqOut, irqOeN, pdOeN, periphBusy, periphAckN, periphErrorInN, eppActive;
  logic dataStrobeOutN, dataStrobeOeN, lineFeedOutN, lineFeedOeN;
  logic periphInitOutN, periphInitOeN, periphSelectOutN, periphSelectOeN;
  logic [10:0] isaAddr;
  logic [7:0]  isaDataIn, isaDataOut, pdOut, pdIn, gotByte, ctlPins;
  logic [3:0]  queueLevelSetting, lag;
  int          mismatches, testsRun, irqCnt, gotCnt, cycles;
  // ==========================================
  // instances and clock
  ecpm_port_ctrl #(.DEPTH(DEPTH)) dut_u (.clk, .sys_rst, .isaAddr, .isaDataIn, .isaRdN,
    .isaWrN, .isaDataOut, .isaDataOeN, .dmaTc, .dmaRun, .eppOption, .queueLevelSetting,
    .irqLineLevel, .irqOut, .irqOeN, .pdIn, .pdOut, .pdOeN, .periphBusy, .periphAckN,
    .periphErrorInN, .dataStrobeOutN, .dataStrobeOeN, .lineFeedOutN, .lineFeedOeN,
    .periphInitOutN, .periphInitOeN, .periphSelectOutN, .periphSelectOeN, .eppActive);
  ecpm_periph_model pm_u (.clk, .sys_rst, .strobeN(dataStrobeOutN), .pdOut, .lag,
    .busy(periphBusy), .ackN(periphAckN), .lastByte(gotByte), .count(gotCnt));
  assign pdIn = pdOeN ? ~pdOut : pdOut;
  assign ctlPins = {periphSelectOutN, periphInitOutN, lineFeedOutN, dataStrobeOutN,
                    periphSelectOeN, periphInitOeN, lineFeedOeN, dataStrobeOeN};
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(negedge irqOeN) if (!sys_rst) irqCnt++;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      mismatches++;
      close_out();
    end
  end
  // ==========================================
  // shared tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    testsRun++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    isaAddr <= a;
    isaDataIn <= d;
    isaWrN <= 1'b0;
    repeat (4) @(posedge clk);
    isaWrN <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task automatic rdChk(input logic [10:0] a, input logic [7:0] e, input string n);
    isaAddr <= a;
    isaRdN <= 1'b0;
    repeat (6) @(posedge clk);
    chk(n, e, isaDataOut);
    isaRdN <= 1'b1;
    repeat (5) @(posedge clk);
  endtask
  // ==========================================
  // scenarios
  task automatic tModes();
    rdChk(OFS_ECR, 8'h05, "ecrReset");
    for (int m = 1; m < 8; m++)
    begin
      wr(OFS_ECR, {m[2:0], 5'h04});
      rdChk(OFS_ECR, {m[2:0], 5'h05}, "ecrMode");
      chk("eppActive", {7'h0, m == 4}, {7'h0, eppActive});
      if (m == 7)
      begin
        wr(OFS_CFGB, 8'hff);
        rdChk(OFS_QUEUE, 8'h10, "cfgA");
        rdChk(OFS_CFGB, {1'b0, irqLineLevel, 6'h0}, "cfgB");
        irqLineLevel <= 1'b0;
        rdChk(OFS_CFGB, 8'h00, "cfgBLow");
        irqLineLevel <= 1'b1;
      end
      wr(OFS_ECR, 8'h04);
    end
    eppOption <= 1'b0;
    wr(OFS_ECR, 8'h84);
    chk("eppOff", 8'h00, {7'h0, eppActive});
    wr(OFS_ECR, 8'h04);
  endtask
  task automatic tQueue();
    int n;
    wr(OFS_ECR, 8'hc4);
    for (int i = 0; i < DEPTH + 1; i++)
      wr(OFS_QUEUE, 8'h30 + 8'(i));
    rdChk(OFS_ECR, 8'hc6, "ecrFull");
    chk("strobeIdle", 8'h01, {7'h0, dataStrobeOutN});
    wr(OFS_ECR, 8'hc0);
    n = irqCnt;
    for (int i = 0; i < DEPTH; i++)
    begin
      rdChk(OFS_QUEUE, 8'h30 + 8'(i), "queueData");
      chk("irqThresh", 8'(n + (i >= 3)), 8'(irqCnt));
    end
    rdChk(OFS_ECR, 8'hc5, "ecrSvcSet");
    wr(OFS_ECR, 8'hc4);
    chk("svcWriteOne", 8'(n + 1), 8'(irqCnt));
    wr(OFS_ECR, 8'hc0);
    chk("svcClear", 8'(n + 2), 8'(irqCnt));
    wr(OFS_ECR, 8'h04);
  endtask
  task automatic tFault();
    int n;
    n = irqCnt;
    wr(OFS_ECR, 8'h74);
    periphErrorInN <= 1'b0;
    repeat (8) @(posedge clk);
    chk("faultMasked", 8'(n), 8'(irqCnt));
    wr(OFS_ECR, 8'h64);
    chk("faultUnmask", 8'(n + 1), 8'(irqCnt));
    periphErrorInN <= 1'b1;
    repeat (8) @(posedge clk);
    periphErrorInN <= 1'b0;
    repeat (8) @(posedge clk);
    chk("faultEdge", 8'(n + 2), 8'(irqCnt));
    wr(OFS_ECR, 8'h04);
  endtask
  task automatic tDma();
    int n;
    wr(OFS_ECR, 8'h48);
    chk("dmaOn", 8'h01, {7'h0, dmaRun});
    n = irqCnt;
    dmaTc <= 1'b1;
    repeat (4) @(posedge clk);
    dmaTc <= 1'b0;
    repeat (10) @(posedge clk);
    chk("dmaTcStop", 8'h00, {7'h0, dmaRun});
    chk("dmaTcIrq", 8'(n + 1), 8'(irqCnt));
    rdChk(OFS_ECR, 8'h4d, "ecrTc");
    wr(OFS_ECR, 8'h40);
    chk("dmaOff", 8'h00, {7'h0, dmaRun});
    wr(OFS_ECR, 8'h04);
  endtask
  task automatic tSend(input logic [7:0] b, input logic [3:0] l);
    int n;
    n = gotCnt;
    lag <= l;
    wr(OFS_ECR, 8'h44);
    wr(OFS_QUEUE, b);
    for (int k = 0; k < 300 && gotCnt != n + 1; k++) @(posedge clk);
    chk("sentByte", b, gotByte);
    repeat (12) @(posedge clk);
    rdChk(OFS_ECR, 8'h45, "sentEmpty");
    wr(OFS_ECR, 8'h04);
    chk("strobeOff", 8'h01, {7'h0, dataStrobeOutN});
  endtask
  task automatic tDir();
    wr(OFS_DATA, 8'h3c);
    wr(OFS_ECR, 8'h24);
    wr(OFS_CTRL, 8'h2c);
    chk("pdFloat", 8'h01, {7'h0, pdOeN});
    chk("pushPull", 8'h70, ctlPins);
    rdChk(OFS_DATA, 8'hc3, "pinRead");
    wr(OFS_ECR, 8'h04);
    chk("dirIgnored", 8'h00, {7'h0, pdOeN});
    chk("openColl", 8'h77, ctlPins);
    chk("pdOut", 8'h3c, pdOut);
    wr(OFS_ECR, 8'h24);
    wr(OFS_CTRL, 8'h00);
    wr(OFS_ECR, 8'h04);
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    isaRdN = 1'b1;
    isaWrN = 1'b1;
    isaAddr = 11'h000;
    isaDataIn = 8'h00;
    dmaTc = 1'b0;
    eppOption = 1'b1;
    irqLineLevel = 1'b1;
    queueLevelSetting = 4'h3;
    periphErrorInN = 1'b1;
    lag = 4'h0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    tModes();
    tDir();
    tQueue();
    tFault();
    tDma();
    tSend(8'ha5, 4'h0);
    tSend(8'h5a, 4'h7);
    close_out();
  end
endmodule // ecp_port_mode_control_bench
bind ecpm_port_ctrl ecpm_port_ctrl_chk chk_u (.clk, .sys_rst, .isaRdN, .isaDataOeN, .dmaTc,
  .dmaRun, .eppOption, .eppActive, .irqOut, .irqOeN, .pdOut, .periphBusy, .dataStrobeOutN,
  .dataStrobeOeN, .lineFeedOutN, .lineFeedOeN);
`default_nettype wire
